/* rtl/pmc_pkg.sv */
// constants, carriers and state types for the module control block
// assumes a single 100 MHz clock; no bus, all control bits are ports
package pmc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int POR_TIME_MS = 140;
    localparam int POR_CYCLES = POR_TIME_MS * (CLK_HZ / 1000);
    localparam int FLT_RST_TIME_US = 10;
    localparam int FLT_RST_CYCLES = FLT_RST_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [6:0] ADDR_ID = 7'h50;
    localparam logic [6:0] ADDR_DIAG = 7'h51;
    localparam int ID_BYTES = 256;
    localparam int N_MON = 5;
    localparam int MON_W = 16;
    localparam logic [7:0] DIAG_ALARM_OFS = 8'h0A;
    localparam logic [7:0] DIAG_WARN_OFS = 8'h0B;
    // input synchroniser lanes
    localparam int SYNC_N = 6;
    localparam int SY_TX_OFF = 0;
    localparam int SY_FAULT = 1;
    localparam int SY_SUPPLY = 2;
    localparam int SY_NOLIGHT = 3;
    localparam int SY_SCL = 4;
    localparam int SY_SDA = 5;
    // pulled-up pins rest high: disable, no light, clock, data
    localparam logic [SYNC_N-1:0] SYNC_RST = 6'h39;
    localparam logic [3:0] BIT_LAST = 4'h8;

    typedef struct packed {
        logic [MON_W-1:0] alarm_hi;
        logic [MON_W-1:0] alarm_lo;
        logic [MON_W-1:0] warn_hi;
        logic [MON_W-1:0] warn_lo;
    } pmc_thr_s;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } pmc_idwr_s;

    typedef enum {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK} pmc_tw_e;
endpackage : pmc_pkg

/* rtl/pmc_thresh.sv */
// threshold comparison of calibrated monitor values
// assumes values and limits arrive on the same clock
`timescale 1ns/1ps
module pmc_thresh import pmc_pkg::*; #(
    parameter int N = N_MON,
    parameter int W = MON_W
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [N-1:0][W-1:0] i_value,
    input wire pmc_thr_s [N-1:0] i_thr,
    output logic [N-1:0][W-1:0] o_value,
    output logic [N-1:0] o_alarm,
    output logic [N-1:0] o_warn
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            wire alarm_next = (i_value[g] > i_thr[g].alarm_hi) || (i_value[g] < i_thr[g].alarm_lo);
            wire warn_next = (i_value[g] > i_thr[g].warn_hi) || (i_value[g] < i_thr[g].warn_lo);
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_value[g] <= '0;
                    o_alarm[g] <= 1'b0;
                    o_warn[g] <= 1'b0;
                end else begin
                    o_value[g] <= i_value[g];
                    o_alarm[g] <= alarm_next;
                    o_warn[g] <= warn_next;
                end
            end
            chk_alarm_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
                (i_value[g] > i_thr[g].alarm_hi) |=> o_alarm[g])
                else $error("alarm flag missed high excursion");
            chk_warn_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
                (i_value[g] < i_thr[g].warn_lo) |=> o_warn[g])
                else $error("warning flag missed low excursion");
            chk_cal_pass: assert property (@(posedge i_clk) disable iff (!i_resetn)
                ##1 o_value[g] == $past(i_value[g]))
                else $error("monitor value altered");
        end
    endgenerate
endmodule : pmc_thresh

/* rtl/pmc_ctl.sv */
// control, status and two-wire management logic of a pluggable module
// assumes pins are pulled up on the host side; the host drives the bus clock
`timescale 1ns/1ps
module pmc_ctl import pmc_pkg::*; #(
    parameter int P_POR_CYCLES = POR_CYCLES,
    parameter int P_N_MON = N_MON
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_supply_ok,
    input wire logic i_transmit_disable,
    input wire logic i_laser_fault,
    input wire logic i_rx_no_light,
    input wire logic i_id_bus_clock,
    input wire logic i_id_bus_data,
    output logic o_id_bus_data,
    output logic o_id_bus_data_oe,
    output logic o_module_present,
    output logic o_module_present_oe,
    output logic o_laser_en,
    output logic o_tx_fault,
    output logic o_no_light_flag,
    output logic [P_N_MON-1:0] o_alarm,
    output logic [P_N_MON-1:0] o_warn,
    input wire pmc_idwr_s i_id_wr,
    input wire logic [P_N_MON-1:0][MON_W-1:0] i_mon_value,
    input wire pmc_thr_s [P_N_MON-1:0] i_thr
);
    localparam int POR_W = $clog2(P_POR_CYCLES + 1);
    localparam int FR_W = $clog2(FLT_RST_CYCLES + 1);

    function automatic logic addr_hit(input logic [7:0] b);
        addr_hit = (b[7:1] == ADDR_ID) || (b[7:1] == ADDR_DIAG);
    endfunction : addr_hit

    // three-stage input capture; a change counts once stages two and three agree
    logic [SYNC_N-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
    wire [SYNC_N-1:0] pins = {i_id_bus_data, i_id_bus_clock, i_rx_no_light,
                              i_supply_ok, i_laser_fault, i_transmit_disable};
    wire [SYNC_N-1:0] flt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & flt_reg);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
            s3_reg <= SYNC_RST;
            flt_reg <= SYNC_RST;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
        end
    end
    wire tx_off_q = flt_reg[SY_TX_OFF];
    wire fault_q = flt_reg[SY_FAULT];
    wire supply_q = flt_reg[SY_SUPPLY];
    wire nl_q = flt_reg[SY_NOLIGHT];
    wire scl = flt_reg[SY_SCL];
    wire sda = flt_reg[SY_SDA];

    // supervisor: restart the hold count on every dip
    logic [POR_W-1:0] por_cnt_reg;
    wire por_active = (por_cnt_reg != POR_W'(P_POR_CYCLES));
    wire [POR_W-1:0] por_cnt_next = !supply_q ? '0 :
                                    por_active ? por_cnt_reg + 1'b1 : por_cnt_reg;
    // fault latch: cleared only by disable held for the reset time
    logic [FR_W-1:0] dis_cnt_reg;
    logic fault_reg, laser_en_reg, nl_reg;
    wire dis_held = (dis_cnt_reg == FR_W'(FLT_RST_CYCLES));
    wire [FR_W-1:0] dis_cnt_next = !tx_off_q ? '0 : dis_held ? dis_cnt_reg : dis_cnt_reg + 1'b1;
    wire fault_next = fault_q | (fault_reg & ~dis_held);
    wire laser_en_next = !tx_off_q && !por_active && !fault_q && !fault_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            por_cnt_reg <= '0;
            dis_cnt_reg <= '0;
            fault_reg <= 1'b0;
            laser_en_reg <= 1'b0;
            nl_reg <= 1'b1;
        end else begin
            por_cnt_reg <= por_cnt_next;
            dis_cnt_reg <= dis_cnt_next;
            fault_reg <= fault_next;
            laser_en_reg <= laser_en_next;
            nl_reg <= nl_q;
        end
    end
    assign o_laser_en = laser_en_reg;
    assign o_tx_fault = fault_reg;
    assign o_no_light_flag = nl_reg;
    assign o_module_present = 1'b0;
    assign o_module_present_oe = 1'b1;

    // diagnostic monitor
    logic [P_N_MON-1:0][MON_W-1:0] mon_q;
    pmc_thresh #(.N(P_N_MON), .W(MON_W)) u_thresh (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_value(i_mon_value),
        .i_thr(i_thr),
        .o_value(mon_q),
        .o_alarm(o_alarm),
        .o_warn(o_warn)
    );

    // identification storage, loaded at manufacture through the write port
    logic [7:0] id_mem [ID_BYTES];
    always_ff @(posedge i_clk) begin
        if (i_id_wr.en) begin
            id_mem[i_id_wr.addr] <= i_id_wr.data;
        end
    end

    // two-wire slave
    pmc_tw_e st_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg, ptr_reg;
    logic dev_reg, rw_reg, first_reg, oe_reg, scl_prev_reg, sda_prev_reg;
    wire scl_rise = scl && !scl_prev_reg;
    wire scl_fall = !scl && scl_prev_reg;
    wire bus_start = scl && scl_prev_reg && sda_prev_reg && !sda;
    wire bus_stop = scl && scl_prev_reg && !sda_prev_reg && sda;
    wire byte_done = scl_fall && (cnt_reg == BIT_LAST);
    wire [7:0] mon_idx = {1'b0, ptr_reg[7:1]};
    wire [MON_W-1:0] mon_word = (mon_idx < 8'(P_N_MON)) ? mon_q[mon_idx] : '0;
    wire [7:0] mon_byte = ptr_reg[0] ? mon_word[7:0] : mon_word[15:8];
    wire [7:0] diag_byte = (ptr_reg < DIAG_ALARM_OFS) ? mon_byte :
                           (ptr_reg == DIAG_ALARM_OFS) ? 8'(o_alarm) :
                           (ptr_reg == DIAG_WARN_OFS) ? 8'(o_warn) : 8'h00;
    // byte source selected by device address
    wire [7:0] rd_byte = dev_reg ? diag_byte : id_mem[ptr_reg];
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= S_IDLE;
            cnt_reg <= '0;
            sh_reg <= '0;
            ptr_reg <= '0;
            dev_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            oe_reg <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
            if (bus_start) begin
                st_reg <= S_ADDR;
                cnt_reg <= '0;
                oe_reg <= 1'b0;
            end else if (bus_stop) begin
                st_reg <= S_IDLE;
                oe_reg <= 1'b0;
            end else begin
                unique case (st_reg)
                    S_IDLE: begin
                        oe_reg <= 1'b0;
                    end
                    S_ADDR, S_WR: begin
                        if (scl_rise) begin
                            sh_reg <= {sh_reg[6:0], sda};
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                        // acknowledge only the two module addresses
                        if (byte_done && st_reg == S_ADDR) begin
                            st_reg <= addr_hit(sh_reg) ? S_AACK : S_IDLE;
                            oe_reg <= addr_hit(sh_reg);
                            dev_reg <= sh_reg[1];
                            rw_reg <= sh_reg[0];
                            first_reg <= !sh_reg[0];
                        end else if (byte_done) begin
                            st_reg <= S_WACK;
                            oe_reg <= 1'b1;
                            first_reg <= 1'b0;
                            if (first_reg) begin
                                ptr_reg <= sh_reg;
                            end
                        end
                    end
                    S_AACK, S_WACK: begin
                        if (scl_fall) begin
                            cnt_reg <= '0;
                            st_reg <= rw_reg ? S_RD : S_WR;
                            oe_reg <= rw_reg ? !rd_byte[7] : 1'b0;
                            if (rw_reg) begin
                                sh_reg <= rd_byte;
                                ptr_reg <= ptr_reg + 1'b1;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_rise) begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                        if (scl_fall) begin
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            oe_reg <= (cnt_reg == BIT_LAST) ? 1'b0 : !sh_reg[6];
                            if (cnt_reg == BIT_LAST) begin
                                st_reg <= S_RACK;
                            end
                        end
                    end
                    S_RACK: begin
                        // host nack ends the read; ack continues at the next byte
                        if (scl_rise) begin
                            st_reg <= sda ? S_IDLE : S_AACK;
                        end
                    end
                endcase
            end
        end
    end
    // open-drain data: drive low only, clock is input only
    assign o_id_bus_data = 1'b0;
    assign o_id_bus_data_oe = oe_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_disable_off: assert property (tx_off_q |=> !o_laser_en)
        else $error("laser on while disabled");
    chk_por_hold: assert property (por_active |=> !o_laser_en)
        else $error("laser on during supervisory reset");
    chk_por_length: assert property ($rose(supply_q) |-> por_active [*8])
        else $error("supervisory reset released too early");
    chk_fault_shut: assert property (fault_q |=> !o_laser_en && o_tx_fault)
        else $error("laser fault not shut down");
    chk_fault_hold: assert property (o_tx_fault && !dis_held |=> o_tx_fault)
        else $error("fault output dropped without disable reset");
    chk_no_light: assert property ($changed(nl_q) |=> o_no_light_flag == $past(nl_q))
        else $error("receive status did not follow detector");
    chk_present_low: assert property (o_module_present_oe && !o_module_present)
        else $error("presence pin not grounded");
    chk_nack_other: assert property (st_reg == S_ADDR && byte_done && !bus_start && !bus_stop
        && !addr_hit(sh_reg) |=> st_reg == S_IDLE && !o_id_bus_data_oe)
        else $error("foreign address acknowledged");
    chk_ack_id: assert property (st_reg == S_ADDR && byte_done && !bus_start && !bus_stop
        && sh_reg[7:1] == ADDR_ID |=> o_id_bus_data_oe && !dev_reg)
        else $error("identification address not acknowledged");
    chk_ack_diag: assert property (st_reg == S_ADDR && byte_done && !bus_start && !bus_stop
        && sh_reg[7:1] == ADDR_DIAG |=> o_id_bus_data_oe && dev_reg)
        else $error("diagnostic address not acknowledged");
    cov_id_ack: cover property (st_reg == S_AACK && !dev_reg);
    cov_diag_read: cover property (st_reg == S_RACK && dev_reg);
    cov_fault: cover property ($fell(o_tx_fault));
    cov_por_done: cover property ($fell(por_active));
endmodule : pmc_ctl

/* verification/pmc_host.sv */
// host-side two-wire master model with bit-level tasks
// assumes a pull-up on the data line only, the clock is driven both ways; the bench calls the tasks
`timescale 1ns/1ps
module pmc_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_lo
);
    // slow bit periods so the module's pin filters keep up
    localparam int HALF = 10;
    initial begin
        o_scl = 1'b1;
        o_sda_lo = 1'b0;
    end
    task automatic hw();
        repeat (HALF) @(posedge i_clk);
    endtask : hw
    task automatic start();
        o_sda_lo <= 1'b0;
        hw();
        o_scl <= 1'b1;
        hw();
        o_sda_lo <= 1'b1;
        hw();
        o_scl <= 1'b0;
        hw();
    endtask : start
    task automatic stop();
        o_sda_lo <= 1'b1;
        hw();
        o_scl <= 1'b1;
        hw();
        o_sda_lo <= 1'b0;
        hw();
    endtask : stop
    // data changes only while clock low, never with the clock edge
    task automatic bitx(input logic b, output logic r);
        o_sda_lo <= ~b;
        hw();
        o_scl <= 1'b1;
        hw();
        r = i_sda;
        hw();
        o_scl <= 1'b0;
        hw();
    endtask : bitx
    task automatic xb(input logic [7:0] w, input logic ak, output logic [7:0] r,
                      output logic a);
        for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
        bitx(ak, a);
    endtask : xb
endmodule : pmc_host

/* verification/pmc_ctl_test.sv */
// self-checking bench for the module control block
// assumes the host model drives the bus; short supervisory count
`timescale 1ns/1ps
module pmc_ctl_test import pmc_pkg::*;;
    localparam int POR = 50;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic sup = 1'b0;
    logic dis = 1'b0;
    logic flt = 1'b0;
    logic nol = 1'b1;
    pmc_idwr_s id_wr = '0;
    logic [N_MON-1:0][MON_W-1:0] mon = '0;
    pmc_thr_s [N_MON-1:0] thr = '0;
    logic scl, h_lo, oe, dd, pres, pres_oe, las, tfl, nlf, ab;
    logic [7:0] rb;
    logic [N_MON-1:0] alm, wrn;
    // open-drain wire with pull-up
    wire sda = ~(h_lo | (oe & ~dd));
    int bad_count = 0;
    int tests_run = 0;
    logic [7:0] got[$];
    always #5 i_clk = ~i_clk;
    pmc_ctl #(.P_POR_CYCLES(POR), .P_N_MON(N_MON)) i_dut (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_supply_ok(sup), .i_transmit_disable(dis),
        .i_laser_fault(flt), .i_rx_no_light(nol), .i_id_bus_clock(scl),
        .i_id_bus_data(sda), .o_id_bus_data(dd), .o_id_bus_data_oe(oe),
        .o_module_present(pres), .o_module_present_oe(pres_oe), .o_laser_en(las),
        .o_tx_fault(tfl), .o_no_light_flag(nlf), .o_alarm(alm), .o_warn(wrn),
        .i_id_wr(id_wr), .i_mon_value(mon), .i_thr(thr));
    pmc_host i_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_lo(h_lo));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input int n);
        logic a;
        logic [7:0] r;
        got.delete();
        i_host.start();
        i_host.xb({dev, 1'b0}, 1'b1, r, a);
        chk("ack addr w", a, 1'b0);
        i_host.xb(ofs, 1'b1, r, a);
        chk("ack ofs", a, 1'b0);
        i_host.start();
        i_host.xb({dev, 1'b1}, 1'b1, r, a);
        chk("ack addr r", a, 1'b0);
        for (int i = 0; i < n; i++) begin
            i_host.xb(8'hFF, i == n - 1, r, a);
            got.push_back(r);
        end
        i_host.stop();
    endtask : rd
    initial begin
        cyc(2);
        i_resetn <= 1'b1;
        chk("laser rst", las, 1'b0);
        chk("no light rst", nlf, 1'b1);
        chk("present", {pres_oe, pres}, 2'b10);
        cyc(2);
        sup <= 1'b1;
        cyc(40);
        chk("laser por", las, 1'b0);
        cyc(30);
        chk("laser on", las, 1'b1);
        sup <= 1'b0;
        cyc(8);
        chk("laser dip", las, 1'b0);
        sup <= 1'b1;
        cyc(40);
        chk("laser por2", las, 1'b0);
        cyc(30);
        chk("laser back", las, 1'b1);
        dis <= 1'b1;
        nol <= 1'b0;
        cyc(8);
        chk("laser dis", las, 1'b0);
        chk("light seen", nlf, 1'b0);
        dis <= 1'b0;
        nol <= 1'b1;
        cyc(8);
        chk("laser en", las, 1'b1);
        chk("light lost", nlf, 1'b1);
        flt <= 1'b1;
        cyc(8);
        chk("fault off", {las, tfl}, 2'b01);
        flt <= 1'b0;
        cyc(20);
        chk("fault held", {las, tfl}, 2'b01);
        dis <= 1'b1;
        cyc(1020);
        dis <= 1'b0;
        cyc(8);
        chk("fault clr", {las, tfl}, 2'b10);
        for (int k = 0; k < N_MON; k++) thr[k] <= '{16'h0400, 16'h0080, 16'h0300, 16'h0100};
        mon <= {16'h0350, 16'h0040, 16'h00C0, 16'h0500, 16'h0200};
        for (int k = 0; k < ID_BYTES; k++) begin
            id_wr <= '{1'b1, k[7:0], k[7:0] ^ 8'h5A};
            cyc(1);
        end
        id_wr <= '0;
        cyc(4);
        chk("alarm", alm, 5'h0A);
        chk("warn", wrn, 5'h1E);
        rd(ADDR_DIAG, 8'h08, 4);
        chk("diag hi", got[0], 8'h03);
        chk("diag lo", got[1], 8'h50);
        chk("diag alarm", got[2], 8'h0A);
        chk("diag warn", got[3], 8'h1E);
        // pointer wraps past the top of the identification map
        rd(ADDR_ID, 8'hFE, 3);
        for (int k = 0; k < 3; k++) chk("id byte", got[k], 8'(k + 254) ^ 8'h5A);
        // bus write of a data byte must leave the identification map alone
        i_host.start();
        i_host.xb({ADDR_ID, 1'b0}, 1'b1, rb, ab);
        i_host.xb(8'h10, 1'b1, rb, ab);
        i_host.xb(8'hA5, 1'b1, rb, ab);
        chk("ack data", ab, 1'b0);
        i_host.stop();
        i_host.start();
        i_host.xb({7'h52, 1'b1}, 1'b1, rb, ab);
        chk("nack other", ab, 1'b1);
        i_host.stop();
        rd(ADDR_ID, 8'h10, 1);
        chk("id after", got[0], 8'h4A);
        summarize();
    end
    initial begin
        // about three times the expected run length
        #300000;
        bad_count++;
        summarize();
    end
endmodule : pmc_ctl_test
